// [hdl/switch_port_pkg.sv]
// Constants shared by the per-port mirroring, VLAN and flow-control block.
package switch_port_pkg;

    // Port count and widths.
    localparam int NUM_PORTS = 5;
    localparam int PORT_IDX_W = 3;
    localparam int VID_W = 12;
    localparam int BYTE_W = 8;
    localparam int AXI_ADDR_W = 9;
    localparam int AXI_DATA_W = 32;
    localparam int REG_IDX_W = 7;
    localparam int IDX_LSB = 2;

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Register indices; the byte address is four times the index.
    localparam logic [REG_IDX_W-1:0] PORT1_MIRROR_VLAN_CTRL_IDX = 7'h11;
    localparam logic [REG_IDX_W-1:0] PORT1_VID_FLOW_CTRL_IDX = 7'h12;
    localparam logic [REG_IDX_W-1:0] PORT2_MIRROR_VLAN_CTRL_IDX = 7'h21;
    localparam logic [REG_IDX_W-1:0] PORT2_VID_FLOW_CTRL_IDX = 7'h22;
    localparam logic [REG_IDX_W-1:0] PORT3_MIRROR_VLAN_CTRL_IDX = 7'h31;
    localparam logic [REG_IDX_W-1:0] PORT3_VID_FLOW_CTRL_IDX = 7'h32;
    localparam logic [REG_IDX_W-1:0] PORT4_MIRROR_VLAN_CTRL_IDX = 7'h41;
    localparam logic [REG_IDX_W-1:0] PORT4_VID_FLOW_CTRL_IDX = 7'h42;
    localparam logic [REG_IDX_W-1:0] PORT5_MIRROR_VLAN_CTRL_IDX = 7'h51;
    localparam logic [REG_IDX_W-1:0] PORT5_VID_FLOW_CTRL_IDX = 7'h52;

    // Index layout: upper field is the port number, lower field the register.
    localparam logic [PORT_IDX_W-1:0] PORT_NUM_FIRST = 3'h1;
    localparam logic [PORT_IDX_W-1:0] PORT_NUM_LAST = 3'h5;
    localparam logic [3:0] SUB_MIRROR = 4'h1;
    localparam logic [3:0] SUB_VIDFLOW = 4'h2;
    localparam logic [3:0] SUB_TAG_HI = 4'h3;
    localparam logic [3:0] SUB_TAG_LO = 4'h4;

    // Field positions.
    localparam int SNIFFER_BIT = 7;
    localparam int RX_SNIFF_BIT = 6;
    localparam int TX_SNIFF_BIT = 5;
    localparam int MEMBER_MSB = 4;
    localparam int VID_FILTER_BIT = 5;
    localparam int FORCE_FC_BIT = 4;
    localparam int VID_HI_MSB = 3;

    // Reset values and writable masks.
    localparam logic [7:0] MIRROR_RST = 8'h1F;
    localparam logic [7:0] VIDFLOW_RST = 8'h00;
    localparam logic [7:0] VIDFLOW_RW_MASK = 8'hF0;
    localparam logic [7:0] TAG_HI_RST = 8'h00;
    localparam logic [7:0] TAG_LO_RST = 8'h01;
    localparam int STRAP_PORT = 3;

endpackage : switch_port_pkg

// [hdl/port_mirror_vlan_flow_ctrl.sv]
// Per-port mirroring, port VLAN, VID filter and flow-control register block.

module port_mirror_vlan_flow_ctrl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [switch_port_pkg::AXI_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [switch_port_pkg::AXI_DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [switch_port_pkg::AXI_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [switch_port_pkg::AXI_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic collision_strap_pin,
    input wire logic fwd_req_valid,
    input wire logic [switch_port_pkg::PORT_IDX_W-1:0] fwd_src_port,
    input wire logic [switch_port_pkg::VID_W-1:0] fwd_vid,
    input wire logic [switch_port_pkg::NUM_PORTS-1:0] fwd_dest_mask,
    output logic fwd_valid,
    output logic [switch_port_pkg::NUM_PORTS-1:0] fwd_mask,
    output logic fwd_discard,
    output logic fwd_monitored,
    input wire logic [switch_port_pkg::NUM_PORTS-1:0] auto_negotiation_result,
    output logic [switch_port_pkg::NUM_PORTS-1:0] flow_ctrl_en
);
    import switch_port_pkg::*;

    // Whole state of the block, registered in one place.
    typedef struct packed {
        logic [NUM_PORTS-1:0][7:0] ctrl1;
        logic [NUM_PORTS-1:0][7:0] ctrl2;
        logic [NUM_PORTS-1:0][7:0] tag_hi;
        logic [NUM_PORTS-1:0][7:0] tag_lo;
        logic aw_have;
        logic w_have;
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic [7:0] w_byte;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [AXI_DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic fwd_valid;
        logic [NUM_PORTS-1:0] fwd_mask;
        logic fwd_discard;
        logic fwd_monitored;
        logic [NUM_PORTS-1:0] flow_en;
    } state_t;

    state_t q_q;
    state_t q_d;

    logic [NUM_PORTS-1:0] sniffer_vec;
    logic [NUM_PORTS-1:0] rx_vec;
    logic [NUM_PORTS-1:0] tx_vec;
    logic [NUM_PORTS-1:0] filt_vec;
    logic [NUM_PORTS-1:0] force_vec;
    logic [NUM_PORTS-1:0][VID_W-1:0] default_vid;
    logic src_ok;
    logic [NUM_PORTS-1:0] member_sel;
    logic drop;
    logic [NUM_PORTS-1:0] base_mask;
    logic rx_hit;
    logic tx_hit;
    logic [NUM_PORTS-1:0] out_mask;

    // Per-port views of the control registers.
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
        assign sniffer_vec[i] = q_q.ctrl1[i][SNIFFER_BIT];
        assign rx_vec[i] = q_q.ctrl1[i][RX_SNIFF_BIT];
        assign tx_vec[i] = q_q.ctrl1[i][TX_SNIFF_BIT];
        assign filt_vec[i] = q_q.ctrl2[i][VID_FILTER_BIT];
        assign force_vec[i] = q_q.ctrl2[i][FORCE_FC_BIT];
        // The default VID spans the low nibble of one byte and the next.
        assign default_vid[i] = {q_q.tag_hi[i][VID_HI_MSB:0],
            q_q.tag_lo[i]};
    end

    // Forwarding decision for one request. An out-of-range source port is
    // dropped rather than indexed, so no unknown value reaches the outputs.
    assign src_ok = fwd_src_port < PORT_IDX_W'(NUM_PORTS);
    assign member_sel = src_ok ?
        q_q.ctrl1[fwd_src_port][MEMBER_MSB:0] : '0;
    assign drop = !src_ok || (filt_vec[fwd_src_port] &&
        fwd_vid != default_vid[fwd_src_port]);
    assign base_mask = fwd_dest_mask & member_sel;
    assign rx_hit = src_ok && rx_vec[fwd_src_port];
    assign tx_hit = |(base_mask & tx_vec);
    // The sniffer copy is added on top; normal destinations stay as they are.
    assign out_mask = drop ? '0 :
        (base_mask | ((rx_hit || tx_hit) ? sniffer_vec : '0));

    // True when a byte address hits one of the implemented registers.
    function automatic logic addr_ok(input logic [AXI_ADDR_W-1:0] addr);
        logic [REG_IDX_W-1:0] idx;
        idx = addr[AXI_ADDR_W-1:IDX_LSB];
        addr_ok = idx[6:4] >= PORT_NUM_FIRST && idx[6:4] <= PORT_NUM_LAST &&
            idx[3:0] >= SUB_MIRROR && idx[3:0] <= SUB_TAG_LO;
    endfunction : addr_ok

    // Byte held at an implemented address; reserved low bits read zero.
    function automatic logic [7:0] read_byte(
        input logic [AXI_ADDR_W-1:0] addr
    );
        logic [REG_IDX_W-1:0] idx;
        logic [PORT_IDX_W-1:0] p;
        idx = addr[AXI_ADDR_W-1:IDX_LSB];
        p = idx[6:4] - PORT_NUM_FIRST;
        unique case (idx[3:0])
            SUB_MIRROR: read_byte = q_q.ctrl1[p];
            SUB_VIDFLOW: read_byte = q_q.ctrl2[p] & VIDFLOW_RW_MASK;
            SUB_TAG_HI: read_byte = q_q.tag_hi[p];
            default: read_byte = q_q.tag_lo[p];
        endcase
    endfunction : read_byte

    // Next-state logic: AXI slave, register writes, forwarding and reset.
    always_comb begin
        logic [REG_IDX_W-1:0] widx;
        logic [PORT_IDX_W-1:0] wp;
        widx = q_q.aw_addr[AXI_ADDR_W-1:IDX_LSB];
        wp = widx[6:4] - PORT_NUM_FIRST;
        q_d = q_q;

        // Write response leaves once the master takes it.
        if (q_q.bvalid && bready) begin
            q_d.bvalid = 1'b0;
        end

        // Both halves held: commit the low byte if lane 0 is enabled and the address is mapped, then answer.
        if (q_q.aw_have && q_q.w_have && !q_q.bvalid) begin
            q_d.aw_have = 1'b0;
            q_d.w_have = 1'b0;
            q_d.bvalid = 1'b1;
            q_d.bresp = addr_ok(q_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            if (addr_ok(q_q.aw_addr) && q_q.w_lane0) begin
                unique case (widx[3:0])
                    SUB_MIRROR: q_d.ctrl1[wp] = q_q.w_byte;
                    SUB_VIDFLOW: begin
                        q_d.ctrl2[wp] = q_q.w_byte & VIDFLOW_RW_MASK;
                    end
                    SUB_TAG_HI: q_d.tag_hi[wp] = q_q.w_byte;
                    default: q_d.tag_lo[wp] = q_q.w_byte;
                endcase
            end
        end

        // Address and data are taken independently, in either order.
        if (awvalid && q_q.awready) begin
            q_d.aw_have = 1'b1;
            q_d.aw_addr = awaddr;
        end
        if (wvalid && q_q.wready) begin
            q_d.w_have = 1'b1;
            q_d.w_byte = wdata[7:0];
            q_d.w_lane0 = wstrb[0];
        end
        q_d.awready = !q_d.aw_have && !q_d.bvalid;
        q_d.wready = !q_d.w_have && !q_d.bvalid;

        // Read channel: one read in flight, data one cycle after the take.
        if (q_q.rvalid && rready) begin
            q_d.rvalid = 1'b0;
        end
        if (arvalid && q_q.arready) begin
            q_d.rvalid = 1'b1;
            q_d.rdata = '0;
            if (addr_ok(araddr)) begin
                q_d.rdata[7:0] = read_byte(araddr);
                q_d.rresp = RESP_OKAY;
            end else begin
                q_d.rresp = RESP_SLVERR;
            end
        end
        q_d.arready = !q_d.rvalid;

        // Forwarding result, registered so every output leaves a flop.
        q_d.fwd_valid = fwd_req_valid;
        q_d.fwd_mask = fwd_req_valid ? out_mask : '0;
        q_d.fwd_discard = fwd_req_valid && drop;
        q_d.fwd_monitored = fwd_req_valid && !drop && (rx_hit || tx_hit);

        // Forced bit overrides the negotiated pause capability.
        q_d.flow_en = force_vec | auto_negotiation_result;

        // Synchronous reset; the strap is sampled while reset is held.
        if (!aresetn) begin
            q_d = '0;
            for (int i = 0; i < NUM_PORTS; i++) begin
                q_d.ctrl1[i] = MIRROR_RST;
                q_d.ctrl2[i] = VIDFLOW_RST;
                q_d.tag_hi[i] = TAG_HI_RST;
                q_d.tag_lo[i] = TAG_LO_RST;
            end
            q_d.ctrl2[STRAP_PORT][FORCE_FC_BIT] = collision_strap_pin;
            q_d.awready = 1'b1;
            q_d.wready = 1'b1;
            q_d.arready = 1'b1;
        end
    end

    // Single state register.
    always_ff @(posedge aclk) begin
        q_q <= q_d;
    end

    assign awready = q_q.awready;
    assign wready = q_q.wready;
    assign bvalid = q_q.bvalid;
    assign bresp = q_q.bresp;
    assign arready = q_q.arready;
    assign rvalid = q_q.rvalid;
    assign rdata = q_q.rdata;
    assign rresp = q_q.rresp;
    assign fwd_valid = q_q.fwd_valid;
    assign fwd_mask = q_q.fwd_mask;
    assign fwd_discard = q_q.fwd_discard;
    assign fwd_monitored = q_q.fwd_monitored;
    assign flow_ctrl_en = q_q.flow_en;

    // Checks on the forwarding and flow-control behaviour.
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    vid_discard_a: assert property (
        fwd_req_valid && src_ok && filt_vec[fwd_src_port] &&
        fwd_vid != default_vid[fwd_src_port]
        |=> fwd_discard && fwd_mask == '0)
        else $error("Mismatching VID was not discarded.");

    member_only_a: assert property (
        fwd_req_valid
        |=> (fwd_mask & ~($past(member_sel) | $past(sniffer_vec))) == '0)
        else $error("Packet forwarded outside its port VLAN.");

    rx_mirror_a: assert property (
        fwd_req_valid && !drop && rx_hit
        |=> fwd_monitored && (fwd_mask & $past(sniffer_vec)) ==
            $past(sniffer_vec))
        else $error("Received packet not copied to the sniffer.");

    tx_mirror_a: assert property (
        fwd_req_valid && !drop && |(base_mask & tx_vec)
        |=> fwd_monitored && (fwd_mask & $past(sniffer_vec)) ==
            $past(sniffer_vec))
        else $error("Transmitted packet not copied to the sniffer.");

    sniffer_quiet_a: assert property (
        fwd_req_valid && !rx_hit && !tx_hit
        |=> !fwd_monitored && fwd_mask == $past(drop ? '0 : base_mask))
        else $error("Unmonitored packet reached the sniffer.");

    normal_kept_a: assert property (
        fwd_req_valid && !drop
        |=> (fwd_mask & $past(base_mask)) == $past(base_mask))
        else $error("Mirroring altered normal delivery.");

    force_fc_a: assert property (
        1'b1 |=> (flow_ctrl_en & $past(force_vec)) == $past(force_vec))
        else $error("Forced flow control not applied.");

    negotiated_fc_a: assert property (
        1'b1 |=> (flow_ctrl_en & ~$past(force_vec)) ==
            ($past(auto_negotiation_result) & ~$past(force_vec)))
        else $error("Flow control does not follow negotiation.");

    strap_reset_a: assert property (
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> force_vec == NUM_PORTS'(
            {1'b0, $past(collision_strap_pin), 3'h0}))
        else $error("Forced flow control reset value wrong.");

    mirror_reset_a: assert property (
        @(posedge aclk) disable iff (1'b0)
        !aresetn |=> q_q.ctrl1 == {NUM_PORTS{MIRROR_RST}} &&
            filt_vec == '0)
        else $error("Control registers not at reset value.");

    discard_seen_c: cover property (fwd_req_valid && drop ##1 fwd_discard);
    rx_mirror_c: cover property (fwd_req_valid && rx_hit && !drop);
    tx_mirror_c: cover property (fwd_req_valid && tx_hit && !drop);
    write_done_c: cover property (bvalid && bready);

endmodule : port_mirror_vlan_flow_ctrl

// [bench/tb_port_mirror_vlan_flow_ctrl.sv]
// Self-checking bench for the per-port mirror, VLAN and flow-control block.
module tb_port_mirror_vlan_flow_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import switch_port_pkg::*;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [AXI_ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, collision_strap_pin = 1'b1;
    logic [AXI_DATA_W-1:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [AXI_DATA_W-1:0] rdata;
    logic fwd_req_valid = 1'b0;
    logic [PORT_IDX_W-1:0] fwd_src_port = '0;
    logic [VID_W-1:0] fwd_vid = '0;
    logic [NUM_PORTS-1:0] fwd_dest_mask = '0, auto_negotiation_result = '0;
    logic fwd_valid, fwd_discard, fwd_monitored;
    logic [NUM_PORTS-1:0] fwd_mask, flow_ctrl_en;
    // Shadow of every register, indexed like the design.
    logic [7:0] sh [128];
    logic [1:0] wq [$];
    logic [33:0] rq [$];
    logic [6:0] fq [$];
    logic [31:0] lf = 32'h59EA;
    int fails = 0, total_checks = 0, cyc = 0;

    port_mirror_vlan_flow_ctrl dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .collision_strap_pin(collision_strap_pin),
        .fwd_req_valid(fwd_req_valid), .fwd_src_port(fwd_src_port),
        .fwd_vid(fwd_vid), .fwd_dest_mask(fwd_dest_mask),
        .fwd_valid(fwd_valid), .fwd_mask(fwd_mask), .fwd_discard(fwd_discard),
        .fwd_monitored(fwd_monitored),
        .auto_negotiation_result(auto_negotiation_result),
        .flow_ctrl_en(flow_ctrl_en));

    // Ten nanosecond clock.
    always #5 aclk = ~aclk;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic mapped(input logic [6:0] i);
        return i[6:4] >= 3'h1 && i[6:4] <= 3'h5 && i[3:0] >= 4'h1
            && i[3:0] <= 4'h4;
    endfunction : mapped

    function automatic logic [11:0] default_vid(input logic [2:0] p);
        return {sh[{p + 3'h1, SUB_TAG_HI}][VID_HI_MSB:0],
            sh[{p + 3'h1, SUB_TAG_LO}]};
    endfunction : default_vid

    // Expected {mask, discard, monitored}; dropped packets are not mirrored.
    function automatic logic [6:0] fwd_exp(input logic [2:0] s,
        input logic [11:0] v, input logic [4:0] d);
        logic [7:0] m;
        logic [4:0] base, snf, txs;
        logic mon;
        for (int i = 0; i < 5; i++) snf[i] = sh[{3'(i + 1), SUB_MIRROR}][7];
        for (int i = 0; i < 5; i++) txs[i] = sh[{3'(i + 1), SUB_MIRROR}][5];
        if (s > 3'h4) return 7'h02;
        m = sh[{s + 3'h1, SUB_MIRROR}];
        if (sh[{s + 3'h1, SUB_VIDFLOW}][5] && v !== default_vid(s))
            return 7'h02;
        base = d & m[4:0];
        mon = m[6] | (|(base & txs));
        return {base | (mon ? snf : 5'h00), 1'b0, mon};
    endfunction : fwd_exp

    task automatic bad(input logic [33:0] e, input logic [33:0] g);
        fails++;
        $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    endtask : bad

    task automatic cmp_rsp(input logic [1:0] g);
        logic [1:0] e;
        e = (wq.size() > 0) ? wq.pop_front() : 2'bxx;
        total_checks++;
        if (g !== e) bad(34'(e), 34'(g));
    endtask : cmp_rsp

    task automatic cmp_rd(input logic [33:0] g);
        logic [33:0] e;
        e = (rq.size() > 0) ? rq.pop_front() : 'x;
        total_checks++;
        if (g !== e) bad(e, g);
    endtask : cmp_rd

    task automatic cmp_fwd(input logic [6:0] g);
        logic [6:0] e;
        e = (fq.size() > 0) ? fq.pop_front() : 'x;
        total_checks++;
        if (g !== e) bad(34'(e), 34'(g));
    endtask : cmp_fwd

    task automatic cmp_fc(input logic [4:0] e, input logic [4:0] g);
        total_checks++;
        if (g !== e) bad(34'(e), 34'(g));
    endtask : cmp_fc

    // Watches every result as it is handed over and checks the oldest note.
    always @(posedge aclk) begin
        if (bvalid === 1'b1 && bready === 1'b1) cmp_rsp(bresp);
        if (rvalid === 1'b1 && rready === 1'b1)
            cmp_rd({rresp, rdata});
        if (fwd_valid === 1'b1)
            cmp_fwd({fwd_mask, fwd_discard,
                fwd_monitored});
    end

    // A hang counts as a mismatch and closes the run.
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    task automatic do_reset(input logic strap);
        aresetn <= 1'b0;
        collision_strap_pin <= strap;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        for (int p = 1; p <= 5; p++) begin
            sh[{3'(p), SUB_MIRROR}] = MIRROR_RST;
            sh[{3'(p), SUB_VIDFLOW}] = VIDFLOW_RST;
            sh[{3'(p), SUB_TAG_HI}] = TAG_HI_RST;
            sh[{3'(p), SUB_TAG_LO}] = TAG_LO_RST;
        end
        sh[{3'(STRAP_PORT + 1), SUB_VIDFLOW}][FORCE_FC_BIT] = strap;
    endtask : do_reset

    // Address and data are offered together and released as each is taken.
    task automatic axi_wr(input logic [6:0] i, input logic [7:0] d,
        input logic [3:0] s);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= {i, 2'h0};
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        wq.push_back(mapped(i) ? RESP_OKAY : RESP_SLVERR);
        if (mapped(i) && s[0])
            sh[i] = (i[3:0] == SUB_VIDFLOW) ? d & VIDFLOW_RW_MASK : d;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [6:0] i);
        @(posedge aclk);
        araddr <= {i, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        rq.push_back(mapped(i) ? {RESP_OKAY, 24'h0, sh[i]}
            : {RESP_SLVERR, 32'h0});
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : axi_rd

    // All twenty registers, then places with no register behind them.
    task automatic rd_all();
        for (int p = 1; p <= 5; p++)
            for (int r = 1; r <= 4; r++) axi_rd({3'(p), 4'(r)});
        axi_rd(7'h10);
        axi_rd(7'h55);
        axi_rd(7'h60);
    endtask : rd_all

    // Random contents, a write with no byte enabled and an unmapped write.
    // The block has no duplex setting, so no port is ever configured as
    // half duplex while its forced flow bit is set.
    task automatic cfg_rand();
        for (int p = 1; p <= 5; p++) begin
            for (int r = 1; r <= 4; r++) begin
                lf = lfsr(lf);
                axi_wr({3'(p), 4'(r)}, lf[7:0], 4'h1);
            end
        end
        axi_wr({3'h2, SUB_MIRROR}, 8'h00, 4'h0);
        axi_wr(7'h10, 8'hFF, 4'h1);
    endtask : cfg_rand

    // Back-to-back requests; half carry the source's default VID.
    task automatic fwd_burst(input int n);
        logic [2:0] s;
        logic [11:0] v;
        for (int k = 0; k < n; k++) begin
            lf = lfsr(lf);
            s = lf[2:0];
            v = lf[8] ? default_vid(s % 3'h5) : lf[20:9];
            fwd_req_valid <= 1'b1;
            fwd_src_port <= s;
            fwd_vid <= v;
            fwd_dest_mask <= lf[7:3];
            fq.push_back(fwd_exp(s, v, lf[7:3]));
            @(posedge aclk);
        end
        fwd_req_valid <= 1'b0;
    endtask : fwd_burst

    task automatic fc_test();
        logic [4:0] e;
        lf = lfsr(lf);
        auto_negotiation_result <= lf[4:0];
        for (int p = 0; p < 5; p++)
            e[p] = sh[{3'(p + 1), SUB_VIDFLOW}][FORCE_FC_BIT] | lf[p];
        repeat (2) @(posedge aclk);
        cmp_fc(e, flow_ctrl_en);
    endtask : fc_test

    // Strap high first, then a second reset in mid-run with it low.
    initial begin
        do_reset(1'b1);
        rd_all();
        fc_test();
        for (int k = 0; k < 4; k++) begin
            cfg_rand();
            rd_all();
            fwd_burst(50);
            repeat (3) @(posedge aclk);
            fc_test();
        end
        do_reset(1'b0);
        rd_all();
        fc_test();
        repeat (3) @(posedge aclk);
        // A result that never appeared leaves its note behind.
        if (wq.size() + rq.size() + fq.size() != 0) bad(34'(fq.size()), '0);
        give_verdict();
    end
endmodule : tb_port_mirror_vlan_flow_ctrl
